// >>> mdbsa_phy_model.sv
// Behavioural PHY and cable partner for the MAC deferral and address block.
// Assumes the bench calls its tasks right after a rising edge of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module mdbsa_phy_model (
  input  wire logic       clock,
  input  wire logic       tx_start,
  output logic            crs_pin,
  output logic            tx_done,
  output logic            collision,
  output logic            rx_frame_start,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte
);
  logic       collide_next;
  logic [2:0] tx_left;
  initial begin
    {crs_pin, tx_done, collision, rx_frame_start, rx_byte_valid, rx_byte} = '0;
    collide_next = 1'b0;
    tx_left = 3'h0;
  end
  // A frame lasts a few cycles, then ends or collides once when the bench asks.
  always @(posedge clock) begin
    tx_done   <= 1'b0;
    collision <= 1'b0;
    if (tx_start) begin
      tx_left <= 3'h5;
    end else if (tx_left != 3'h0) begin
      tx_left <= tx_left - 3'h1;
      if (tx_left == 3'h1) begin
        collision    <= collide_next;
        tx_done      <= !collide_next;
        collide_next <= 1'b0;
      end
    end
  end
  // Carrier follows the bench, so deferral can be made as long as needed.
  task automatic carrier(input logic on);
    @(posedge clock);
    crs_pin <= on;
  endtask : carrier
  // lowest byte first
  // A released data line shows the inverse so a stale byte never looks valid.
  task automatic send_frame(input logic [47:0] addr);
    @(posedge clock);
    rx_frame_start <= 1'b1;
    for (int n = 0; n < 6; n++) begin
      @(posedge clock);
      rx_frame_start <= 1'b0;
      rx_byte_valid  <= 1'b1;
      rx_byte        <= addr[8*n +: 8];
    end
    @(posedge clock);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~rx_byte;
  endtask : send_frame
endmodule : mdbsa_phy_model
`default_nettype wire

// >>> mdbsa_pkg.sv
// Shared constants for the MAC deferral, backoff and station address block.
// Assumes a 25 MHz system clock and register access over a 32-bit AHB-Lite slave.
package mdbsa_pkg;
  // Register indexes; the byte address is four times the index.
  localparam logic [5:0]  IDX_CONTROL      = 6'h01;
  localparam logic [5:0]  IDX_ADDR_UPPER   = 6'h02;
  localparam logic [5:0]  IDX_ADDR_LOWER   = 6'h03;
  localparam logic [5:0]  IDX_IRQ_STATUS   = 6'h08;
  localparam logic [5:0]  IDX_IRQ_MASK     = 6'h09;
  localparam logic [5:0]  IDX_INIT_STATUS  = 6'h0a;
  // Reset values.
  localparam logic [31:0] RST_CONTROL      = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR_UPPER   = 32'h0000_0fff;
  localparam logic [31:0] RST_ADDR_LOWER   = 32'h0fff_ffff;
  localparam logic [15:0] ADDR_UPPER_MASK  = 16'hffff;
  // Control register fields.
  localparam int          BIT_RX_ON        = 2;
  localparam int          BIT_TX_ON        = 3;
  localparam int          BIT_DEFER_CHK    = 5;
  localparam int          POS_BACKOFF_SEL  = 6;
  // Interrupt status bits.
  localparam int          EV_DEFER_ABORT   = 0;
  localparam int          EV_BACKOFF_DONE  = 1;
  localparam int          EV_ADDR_MATCH    = 2;
  localparam int          EV_INIT_DONE     = 3;
  localparam int          NUM_EVENTS       = 4;
  // Serial EEPROM locations of the station address bytes.
  localparam logic [7:0]  EE_ADDR_FIRST    = 8'h01;
  localparam logic [7:0]  EE_ADDR_UPPER_LO = 8'h05;
  localparam logic [7:0]  EE_ADDR_UPPER_HI = 8'h06;
  // Backoff limit selections and the LFSR bits each one keeps.
  localparam logic [9:0]  LIM_MASK_00      = 10'h3ff;
  localparam logic [9:0]  LIM_MASK_01      = 10'h0ff;
  localparam logic [9:0]  LIM_MASK_10      = 10'h00f;
  localparam logic [9:0]  LIM_MASK_11      = 10'h001;
  localparam logic [3:0]  BACKOFF_K_MAX    = 4'ha;
  localparam logic [9:0]  LFSR_SEED        = 10'h001;
  // Timing: the timers advance in nibble times of the link.
  localparam int          BITS_PER_NIBBLE  = 4;
  localparam int          CLK_MHZ          = 25;
  localparam int          RATE_10_MBPS     = 10;
  localparam int          NIB_CLK_10M      = (CLK_MHZ * BITS_PER_NIBBLE) / RATE_10_MBPS;
  localparam logic [3:0]  NIB_DIV_LAST     = 4'(NIB_CLK_10M - 1);
  localparam int          SLOT_BITS        = 512;
  localparam int          DEFER_LIMIT_BITS = 24288;
  localparam int          MAC_BYTES        = 6;
endpackage : mdbsa_pkg

// >>> mdbsa_top.sv
// MAC transmit deferral, collision backoff, enable bits and station address registers.
// Assumes tx_frame_ready, collision, retry_count, link_100, EEPROM and receive byte
// inputs come from logic on the same clock; carrier sense comes from a pin.
//
// Summary of operation
// - Backoff wait is taken from the LFSR; limit 00 with K=10 uses ten bits.
// - Limit setting keeps 10, 8, 4 or 1 LFSR bits for 00, 01, 10, 11.
// - Backoff wait counts down in slot times of 512 bit times.
// - With deferral check on, abort the attempt after deferring over 24288 bit times.
// - Deferral counts only while a frame is ready but carrier sense holds it off.
// - Deferral time never accumulates; each new deferral restarts the timer at zero.
// - With deferral check off (bit 5 clear), defer without limit until carrier clears.
// - Transmitter on lets frames go onto the cable; off keeps the transmitter disabled.
// - Receiver on accepts frames from the PHY; off keeps the receiver disabled.
// - Upper address register holds address bits 47:32 in 15:0; 31:16 reserved.
// - Power-on load puts EEPROM 0x05 in bits 7:0 and 0x06 in bits 15:8.
// - The power-on load happens only if a programmed EEPROM is detected.
// - After initialisation the host may overwrite the upper station address.
// - Address bytes match in reception order; 0x05 is fifth, 0x06 sixth.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mdbsa_top #(
  parameter int DEFER_LIMIT_BITS = mdbsa_pkg::DEFER_LIMIT_BITS,
  parameter int SLOT_BITS        = mdbsa_pkg::SLOT_BITS
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        crs_pin,
  input  wire logic        link_100,
  input  wire logic        tx_frame_ready,
  input  wire logic        tx_done,
  input  wire logic        collision,
  input  wire logic [3:0]  retry_count,
  output logic             tx_start,
  output logic             tx_busy,
  output logic             defer_abort,
  output logic             backoff_active,
  input  wire logic        ee_byte_valid,
  input  wire logic [7:0]  ee_byte_addr,
  input  wire logic [7:0]  ee_byte,
  input  wire logic        ee_programmed,
  input  wire logic        ee_load_done,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_enable,
  output logic             addr_match,
  output logic             irq
);
  // Limits in nibble times; least times round up.
  localparam int DEFER_NIB = (DEFER_LIMIT_BITS + mdbsa_pkg::BITS_PER_NIBBLE - 1)
                             / mdbsa_pkg::BITS_PER_NIBBLE;
  localparam int SLOT_NIB  = SLOT_BITS / mdbsa_pkg::BITS_PER_NIBBLE;
  localparam logic [15:0] DEFER_NIB_W = 16'(DEFER_NIB);
  localparam logic [7:0]  SLOT_LAST   = 8'(SLOT_NIB - 1);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_DEFER   = 4'b0010,
    ST_TX      = 4'b0100,
    ST_BACKOFF = 4'b1000
  } mdbsa_state_e;

  mdbsa_state_e state;
  logic [31:0]  control;
  logic [15:0]  addr_upper;
  logic [31:0]  addr_lower;
  logic [mdbsa_pkg::NUM_EVENTS-1:0] irq_status;
  logic [mdbsa_pkg::NUM_EVENTS-1:0] irq_mask;
  logic [mdbsa_pkg::NUM_EVENTS-1:0] event_set;
  logic         init_done;
  logic         crs_meta, crs_s2, crs_s3, crs;
  logic [3:0]   nib_div;
  logic         nib_tick;
  logic [15:0]  defer_cnt;
  logic [7:0]   slot_cnt;
  logic [9:0]   wait_slots;
  logic [9:0]   lfsr;
  logic [9:0]   k_mask, lim_mask, next_wait;
  logic [2:0]   rx_idx;
  logic         rx_miss;
  logic         wr_pend;
  logic [5:0]   wr_idx;
  logic [31:0]  read_mux;
  logic [47:0]  station;
  logic         tx_on, rx_on, defer_chk, backoff_fin;
  logic [1:0]   backoff_sel;

  assign tx_on       = control[mdbsa_pkg::BIT_TX_ON];
  assign rx_on       = control[mdbsa_pkg::BIT_RX_ON];
  assign defer_chk   = control[mdbsa_pkg::BIT_DEFER_CHK];
  assign backoff_sel = control[mdbsa_pkg::POS_BACKOFF_SEL +: 2];
  assign station     = {addr_upper, addr_lower};

  // Carrier sense is asynchronous; a change counts once two later stages agree.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crs_meta <= 1'b0;
      crs_s2   <= 1'b0;
      crs_s3   <= 1'b0;
      crs      <= 1'b0;
    end else begin
      crs_meta <= crs_pin;
      crs_s2   <= crs_meta;
      crs_s3   <= crs_s2;
      if (crs_s2 == crs_s3) begin
        crs <= crs_s3;
      end
    end
  end

  // nibble time tick
  // One nibble is one clock at 100 Mb/s, ten clocks at 10 Mb/s.
  always_ff @(posedge clock) begin
    if (sys_rst || link_100 || nib_div == mdbsa_pkg::NIB_DIV_LAST) begin
      nib_div <= '0;
    end else begin
      nib_div <= nib_div + 4'h1;
    end
  end
  assign nib_tick = link_100 || (nib_div == mdbsa_pkg::NIB_DIV_LAST);

  // Free-running LFSR; its value at the collision seeds the backoff wait.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfsr <= mdbsa_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
    end
  end

  // backoff bit selection
  // The narrower of the retry window and the limit setting wins.
  always_comb begin
    if (retry_count >= mdbsa_pkg::BACKOFF_K_MAX) begin
      k_mask = mdbsa_pkg::LIM_MASK_00;
    end else begin
      k_mask = 10'((11'h001 << retry_count) - 11'h001);
    end
    case (backoff_sel)
      2'h0:    lim_mask = mdbsa_pkg::LIM_MASK_00;
      2'h1:    lim_mask = mdbsa_pkg::LIM_MASK_01;
      2'h2:    lim_mask = mdbsa_pkg::LIM_MASK_10;
      default: lim_mask = mdbsa_pkg::LIM_MASK_11;
    endcase
    next_wait = lfsr & k_mask & lim_mask;
  end

  // backoff ends when no slots are left.
  assign backoff_fin = (wait_slots == '0);

  // Transmit attempt sequencer: defer on carrier, transmit, back off on collision.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      tx_start    <= 1'b0;
      defer_abort <= 1'b0;
    end else begin
      tx_start    <= 1'b0;
      defer_abort <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (tx_on && tx_frame_ready) begin
            if (crs) begin
              state <= ST_DEFER;
            end else begin
              state    <= ST_TX;
              tx_start <= 1'b1;
            end
          end
        end
        ST_DEFER: begin
          if (!tx_on || !tx_frame_ready) begin
            state <= ST_IDLE;
          end else if (!crs) begin
            state    <= ST_TX;
            tx_start <= 1'b1;
          end else if (defer_chk && defer_cnt > DEFER_NIB_W) begin
            state       <= ST_IDLE;
            defer_abort <= 1'b1;
          end
        end
        ST_TX: begin
          if (collision) begin
            state <= ST_BACKOFF;
          end else if (tx_done) begin
            state <= ST_IDLE;
          end
        end
        ST_BACKOFF: begin
          if (backoff_fin) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // deferral timer
  // Counts only in the defer state, so every new deferral starts from zero.
  always_ff @(posedge clock) begin
    if (sys_rst || state != ST_DEFER) begin
      defer_cnt <= '0;
    end else if (nib_tick && defer_cnt != '1) begin
      defer_cnt <= defer_cnt + 16'h0001;
    end
  end

  // slot countdown
  // The wait is loaded on the collision and falls by one per slot.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_slots <= '0;
      slot_cnt   <= '0;
    end else if (state == ST_TX && collision) begin
      wait_slots <= next_wait;
      slot_cnt   <= '0;
    end else if (state == ST_BACKOFF && !backoff_fin && nib_tick) begin
      if (slot_cnt == SLOT_LAST) begin
        slot_cnt   <= '0;
        wait_slots <= wait_slots - 10'h001;
      end else begin
        slot_cnt <= slot_cnt + 8'h01;
      end
    end
  end

  // Status outputs registered so they come straight from flops.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_busy        <= 1'b0;
      backoff_active <= 1'b0;
      rx_enable      <= 1'b0;
    end else begin
      tx_busy        <= (state == ST_TX);
      backoff_active <= (state == ST_BACKOFF);
      rx_enable      <= rx_on;
    end
  end

  // destination match in reception order
  // Bytes are ignored while the receiver is off.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_idx     <= '0;
      rx_miss    <= 1'b0;
      addr_match <= 1'b0;
    end else begin
      addr_match <= 1'b0;
      if (rx_frame_start) begin
        rx_idx  <= '0;
        rx_miss <= 1'b0;
      end else if (rx_on && rx_byte_valid && rx_idx < 3'(mdbsa_pkg::MAC_BYTES)) begin
        rx_idx <= rx_idx + 3'h1;
        if (rx_byte != station[8*rx_idx +: 8]) begin
          rx_miss <= 1'b1;
        end else if (rx_idx == 3'(mdbsa_pkg::MAC_BYTES - 1) && !rx_miss) begin
          addr_match <= 1'b1;
        end
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY, read data set up at address phase.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      wr_pend   <= 1'b0;
      wr_idx    <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend <= hwrite;
        wr_idx  <= haddr[7:2];
        if (!hwrite) begin
          hrdata <= read_mux;
        end
      end
    end
  end

  // Read decode; unmapped words and reserved bits read as zero.
  always_comb begin
    if (haddr[7:2] == mdbsa_pkg::IDX_CONTROL) begin
      read_mux = control;
    end else if (haddr[7:2] == mdbsa_pkg::IDX_ADDR_UPPER) begin
      read_mux = {16'h0000, addr_upper};
    end else if (haddr[7:2] == mdbsa_pkg::IDX_ADDR_LOWER) begin
      read_mux = addr_lower;
    end else if (haddr[7:2] == mdbsa_pkg::IDX_IRQ_STATUS) begin
      read_mux = 32'(irq_status);
    end else if (haddr[7:2] == mdbsa_pkg::IDX_IRQ_MASK) begin
      read_mux = 32'(irq_mask);
    end else if (haddr[7:2] == mdbsa_pkg::IDX_INIT_STATUS) begin
      read_mux = {31'h0, init_done};
    end else begin
      read_mux = '0;
    end
  end

  // Control register written by software.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      control <= mdbsa_pkg::RST_CONTROL;
    end else if (wr_pend && wr_idx == mdbsa_pkg::IDX_CONTROL) begin
      control <= hwdata;
    end
  end

  // Station address: EEPROM load at power-on, host writes only afterwards.
  // Host writes are dropped before init so a load cannot be half overwritten.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_upper <= mdbsa_pkg::RST_ADDR_UPPER[15:0];
      addr_lower <= mdbsa_pkg::RST_ADDR_LOWER;
    end else if (!init_done) begin
      if (ee_byte_valid && ee_programmed) begin
        if (ee_byte_addr == mdbsa_pkg::EE_ADDR_UPPER_LO) begin
          addr_upper[7:0] <= ee_byte;
        end else if (ee_byte_addr == mdbsa_pkg::EE_ADDR_UPPER_HI) begin
          addr_upper[15:8] <= ee_byte;
        end else if (ee_byte_addr >= mdbsa_pkg::EE_ADDR_FIRST
                     && ee_byte_addr < mdbsa_pkg::EE_ADDR_UPPER_LO) begin
          // The byte index is cut to two bits so location 0x04 wraps to the top byte.
          addr_lower[8*(2'(ee_byte_addr[1:0] - 2'h1)) +: 8] <= ee_byte;
        end
      end
    end else if (wr_pend && wr_idx == mdbsa_pkg::IDX_ADDR_UPPER) begin
      addr_upper <= hwdata[15:0] & mdbsa_pkg::ADDR_UPPER_MASK;
    end else if (wr_pend && wr_idx == mdbsa_pkg::IDX_ADDR_LOWER) begin
      addr_lower <= hwdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      init_done <= 1'b0;
    end else if (ee_load_done) begin
      init_done <= 1'b1;
    end
  end

  // Sticky events, write one to clear; a new event wins over a clear.
  assign event_set[mdbsa_pkg::EV_DEFER_ABORT]  = defer_abort;
  assign event_set[mdbsa_pkg::EV_BACKOFF_DONE] = (state == ST_BACKOFF) && backoff_fin;
  assign event_set[mdbsa_pkg::EV_ADDR_MATCH]   = addr_match;
  assign event_set[mdbsa_pkg::EV_INIT_DONE]    = ee_load_done && !init_done;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_pend && wr_idx == mdbsa_pkg::IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~hwdata[mdbsa_pkg::NUM_EVENTS-1:0]) | event_set;
      end else begin
        irq_status <= irq_status | event_set;
      end
      if (wr_pend && wr_idx == mdbsa_pkg::IDX_IRQ_MASK) begin
        irq_mask <= hwdata[mdbsa_pkg::NUM_EVENTS-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // Checks on the sequencer and registers.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_tx_needs_enable: assert property (
    tx_start |-> $past(tx_on)) else $error("Transmit started while transmitter off.");
  chk_defer_ready_crs: assert property (
    (state == ST_DEFER && defer_cnt != '0) |-> $past(crs) && $past(tx_frame_ready))
    else $error("Deferral counted without carrier or frame.");
  chk_defer_restart: assert property (
    (state == ST_BACKOFF ##1 state == ST_IDLE) |-> defer_cnt == '0)
    else $error("Deferral timer not cleared after backoff.");
  chk_abort_limit: assert property (
    defer_abort |-> $past(defer_cnt) > DEFER_NIB_W && $past(defer_chk))
    else $error("Deferral abort before the limit.");
  chk_no_abort_off: assert property (
    !defer_chk && state == ST_DEFER && crs && tx_on && tx_frame_ready |=> !defer_abort)
    else $error("Abort while deferral check off.");
  chk_backoff_bits: assert property (
    (state == ST_TX && collision) |=> (wait_slots & ~lim_mask) == '0)
    else $error("Backoff wait exceeds the limit bits.");
  chk_backoff_k10: assert property (
    (state == ST_TX && collision && backoff_sel == 2'h0 && retry_count == 4'ha)
    |=> wait_slots == $past(lfsr)) else $error("Ten-bit backoff not taken from LFSR.");
  chk_slot_length: assert property (
    (state == ST_BACKOFF && link_100 && slot_cnt == SLOT_LAST && !backoff_fin
     && wait_slots == 10'h001) |=> backoff_fin)
    else $error("Slot countdown did not end the wait.");
  chk_upper_reserved: assert property (
    (hreadyout && $past(hsel && htrans[1] && !hwrite && haddr[7:2] ==
     mdbsa_pkg::IDX_ADDR_UPPER)) |-> hrdata[31:16] == 16'h0000)
    else $error("Reserved address bits read non-zero.");
  chk_load_only_prog: assert property (
    (!init_done && !(ee_byte_valid && ee_programmed) && !wr_pend) |=> $stable(addr_upper))
    else $error("Address changed without a programmed EEPROM.");
  chk_rx_off: assert property (
    !rx_on |=> !addr_match) else $error("Match reported with receiver off.");
  chk_irq_level: assert property (
    irq == $past(|(irq_status & irq_mask))) else $error("Interrupt level wrong.");

  cov_defer_abort:   cover property (defer_abort);
  cov_backoff_cycle: cover property (state == ST_TX && collision ##[1:300] state == ST_IDLE);
  cov_addr_match:    cover property (addr_match);
  cov_host_write:    cover property (init_done && wr_pend && wr_idx == mdbsa_pkg::IDX_ADDR_UPPER);
endmodule : mdbsa_top
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the MAC deferral, backoff and station address block.
// Assumes an AHB-Lite slave that answers in under fifty cycles and shortened timer parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        link_100 = 1'b1;
  logic        tx_frame_ready = 1'b0;
  logic [3:0]  retry_count = 4'ha;
  logic        ee_byte_valid = 1'b0;
  logic [7:0]  ee_byte_addr = '0;
  logic [7:0]  ee_byte = '0;
  logic        ee_programmed = 1'b0;
  logic        ee_load_done = 1'b0;
  logic        hreadyout, hresp, tx_start, tx_busy, defer_abort, backoff_active;
  logic        crs_pin, tx_done, collision, rx_frame_start, rx_byte_valid;
  logic        rx_enable, addr_match, irq;
  logic [7:0]  rx_byte;
  logic [31:0] hrdata, rd;
  int          errors = 0, num_checks = 0, n_start = 0, n_abort = 0, n_match = 0;
  int          bo_cycles = 0;
  mdbsa_top #(.DEFER_LIMIT_BITS(64), .SLOT_BITS(16)) u_mdbsa_top (
    .clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .crs_pin, .link_100,
    .tx_frame_ready, .tx_done, .collision, .retry_count, .tx_start, .tx_busy,
    .defer_abort, .backoff_active, .ee_byte_valid, .ee_byte_addr, .ee_byte,
    .ee_programmed, .ee_load_done, .rx_frame_start, .rx_byte_valid, .rx_byte,
    .rx_enable, .addr_match, .irq);
  mdbsa_phy_model u_phy_model (.clock, .tx_start, .crs_pin, .tx_done, .collision,
    .rx_frame_start, .rx_byte_valid, .rx_byte);
  initial forever #20 clock = ~clock;
  // Events are counted on the falling edge, where the outputs have settled.
  always @(negedge clock) begin
    if (tx_start === 1'b1) n_start++;
    if (defer_abort === 1'b1) n_abort++;
    if (addr_match === 1'b1) n_match++;
    if (backoff_active === 1'b1) bo_cycles++;
  end
  task automatic final_report();
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // One single AHB-Lite word transfer; a hung slave ends the run.
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
        errors++;
        final_report();
      end
      if (p == 0) begin
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
      end
    end
    rd = hrdata;
    check(hresp, 32'h0, "bus response");
  endtask : bus
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset
  // Station bytes 0x11 to 0x16 sit at EEPROM locations 0x01 to 0x06.
  task automatic ee_load(input logic prog);
    ee_programmed <= prog;
    for (int a = 1; a <= 6; a++) begin
      @(posedge clock);
      ee_byte_valid <= 1'b1;
      ee_byte_addr  <= 8'(a);
      ee_byte       <= 8'h10 + 8'(a);
    end
    @(posedge clock);
    ee_byte_valid <= 1'b0;
    ee_load_done  <= 1'b1;
    @(posedge clock);
    ee_load_done <= 1'b0;
  endtask : ee_load
  task automatic rx_case(input logic [31:0] ctrl, input logic [47:0] a, input int exp);
    bus(1'b1, mdbsa_pkg::IDX_CONTROL, ctrl);
    n_match = 0;
    u_phy_model.send_frame(a);
    repeat (4) @(posedge clock);
    check(n_match, exp, "address match");
    check(rx_enable, ctrl[mdbsa_pkg::BIT_RX_ON], "receiver enable");
  endtask : rx_case
  // Carrier is raised first so the synchroniser shows it before the frame is ready.
  task automatic defer_case(input logic [31:0] ctrl, input int lo, hi, exp);
    int k;
    bus(1'b1, mdbsa_pkg::IDX_CONTROL, ctrl);
    u_phy_model.carrier(1'b1);
    repeat (5) @(posedge clock);
    n_abort = 0;
    n_start = 0;
    tx_frame_ready <= 1'b1;
    repeat (lo) @(posedge clock);
    check(n_abort, 0, "early abort");
    repeat (hi - lo) @(posedge clock);
    check(n_abort, exp, "abort count");
    check(n_start, 0, "start under carrier");
    u_phy_model.carrier(1'b0);
    for (k = 0; k < 12 && n_start == 0; k++) @(posedge clock);
    tx_frame_ready <= 1'b0;
    check(n_start, 1, "start after carrier");
    @(negedge clock);
    check(tx_busy, 1, "busy after start");
    repeat (12) @(posedge clock);
  endtask : defer_case
  // Backoff length is bounded by the kept LFSR bits, four cycles to a slot.
  task automatic backoff_case(input logic [1:0] sel, input int max_slots);
    int k;
    bus(1'b1, mdbsa_pkg::IDX_CONTROL, 32'h8 | {sel, 6'h0});
    n_start = 0;
    bo_cycles = 0;
    u_phy_model.collide_next <= 1'b1;
    tx_frame_ready <= 1'b1;
    for (k = 0; k < max_slots * 4 + 60 && n_start < 2; k++) @(posedge clock);
    tx_frame_ready <= 1'b0;
    check(n_start, 2, "retry after backoff");
    check(bo_cycles <= max_slots * 4 + 3, 1, "backoff length");
    repeat (12) @(posedge clock);
  endtask : backoff_case
  initial begin
    do_reset();
    bus(1'b0, mdbsa_pkg::IDX_ADDR_UPPER, 0);
    check(rd, 32'h0000_0fff, "upper reset");
    bus(1'b0, 6'h3f, 0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, mdbsa_pkg::IDX_ADDR_UPPER, 32'h1234);
    bus(1'b0, mdbsa_pkg::IDX_ADDR_UPPER, 0);
    check(rd, 32'h0000_0fff, "write before init");
    ee_load(1'b0);
    bus(1'b0, mdbsa_pkg::IDX_ADDR_UPPER, 0);
    check(rd, 32'h0000_0fff, "unprogrammed load");
    do_reset();
    ee_load(1'b1);
    bus(1'b0, mdbsa_pkg::IDX_ADDR_UPPER, 0);
    check(rd, 32'h0000_1615, "eeprom load");
    bus(1'b0, mdbsa_pkg::IDX_ADDR_LOWER, 0);
    check(rd, 32'h1413_1211, "lower load");
    rx_case(32'h4, 48'h1615_1413_1211, 1);
    rx_case(32'h0, 48'h1615_1413_1211, 0);
    bus(1'b1, mdbsa_pkg::IDX_ADDR_UPPER, 32'hffff_5a5a);
    bus(1'b0, mdbsa_pkg::IDX_ADDR_UPPER, 0);
    check(rd, 32'h0000_5a5a, "host write");
    rx_case(32'h4, 48'h5a5a_1413_1211, 1);
    rx_case(32'h4, 48'h5a5a_1413_1112, 0);
    bus(1'b1, mdbsa_pkg::IDX_CONTROL, 32'h0);
    n_start = 0;
    tx_frame_ready <= 1'b1;
    repeat (20) @(posedge clock);
    tx_frame_ready <= 1'b0;
    check(n_start, 0, "transmitter off");
    defer_case(32'h28, 12, 28, 1);
    link_100 <= 1'b0;
    defer_case(32'h28, 150, 200, 1);
    link_100 <= 1'b1;
    defer_case(32'h08, 300, 300, 0);
    bus(1'b0, mdbsa_pkg::IDX_IRQ_STATUS, 0);
    check(rd[0], 1, "abort status");
    check(irq, 0, "masked irq");
    bus(1'b1, mdbsa_pkg::IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 1, "unmasked irq");
    bus(1'b1, mdbsa_pkg::IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 0, "cleared irq");
    backoff_case(2'b00, 1023);
    backoff_case(2'b01, 255);
    backoff_case(2'b10, 15);
    backoff_case(2'b11, 1);
    retry_count <= 4'h2;
    backoff_case(2'b00, 3);
    final_report();
  end
  // Guard against a hang anywhere in the sequence.
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    final_report();
  end
endmodule : tb
`default_nettype wire
